// ==== core/alert_status_and_alarm_assertion_timer.sv ====
// Purpose: Sticky status, alert masking, pin function select and alarm assertion timer
// Assumes: Register port strobes come from same-clock serial interface logic
// Notes: Open-drain pins use out/oe pairs; the wire level is resolved outside
`timescale 1ns/1ps
`default_nettype none
module alert_status_and_alarm_assertion_timer #(
   parameter int TICK_CYCLES = alert_timer_pkg::TIMER_STEP_CYCLES
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire alert_timer_pkg::reg_req_s reg_req,
   output logic [7:0] reg_rdata,
   input wire alert_timer_pkg::limit_events_s limit_events,
   input wire logic vid_change_sel,
   input wire logic [4:0] voltage_id_inputs,
   input wire logic pin22_in_n,
   input wire logic pin14_in,
   input wire logic second_fan_drive_output,
   input wire logic fans_running,
   output logic pin10_out,
   output logic pin10_oe,
   output logic pin14_out,
   output logic pin14_oe,
   output logic fans_full_speed
);
   initial begin
      if (TICK_CYCLES < 1 || TICK_CYCLES > 16777215) begin
         $error("TICK_CYCLES out of range");
      end
   end

   // ****************************************
   // Input synchronisers
   // ****************************************
   logic [6:0] pin_meta_reg;
   logic [6:0] pin_sync_reg;
   logic [4:0] vid_prev_reg;

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         // Alarm pins reset to their idle high level, so release is no false alarm
         pin_meta_reg <= 7'h03;
         pin_sync_reg <= 7'h03;
      end else begin
         pin_meta_reg <= {voltage_id_inputs, pin14_in, pin22_in_n};
         pin_sync_reg <= pin_meta_reg;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         vid_prev_reg <= 5'h00;
      end else begin
         vid_prev_reg <= pin_sync_reg[6:2];
      end
   end

   // ****************************************
   // Configuration and mask registers
   // ****************************************
   logic [7:0] mask1_reg;
   logic [7:0] mask2_reg;
   logic [7:0] config3_reg;
   logic [7:0] config4_reg;
   logic [7:0] timer_limit_reg;

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         mask1_reg <= alert_timer_pkg::MASK_RESET;
         mask2_reg <= alert_timer_pkg::MASK_RESET;
         config3_reg <= alert_timer_pkg::CONFIG_RESET;
         config4_reg <= alert_timer_pkg::CONFIG_RESET;
         timer_limit_reg <= alert_timer_pkg::TIMER_LIMIT_RESET;
      end else if (reg_req.wr) begin
         case (reg_req.addr)
            alert_timer_pkg::ADDR_MASK1: mask1_reg <= reg_req.wdata;
            alert_timer_pkg::ADDR_MASK2: mask2_reg <= reg_req.wdata;
            alert_timer_pkg::ADDR_CONFIG3: config3_reg <= reg_req.wdata;
            alert_timer_pkg::ADDR_CONFIG4: config4_reg <= reg_req.wdata;
            alert_timer_pkg::ADDR_TIMER_LIMIT: timer_limit_reg <= reg_req.wdata;
            default: ;
         endcase
      end
   end

   // ****************************************
   // Pin functions and alarm input
   // ****************************************
   alert_timer_pkg::pin14_mode_e pin14_mode;
   logic alarm_enable;
   logic pin22_alarm;
   logic pin14_alarm;
   logic alarm_asserted;
   logic vid_changed;
   logic rd_status1;
   logic rd_status2;
   logic rd_timer;

   assign pin14_mode = alert_timer_pkg::pin14_mode_e'(config4_reg[1:0]);
   assign alarm_enable = config3_reg[alert_timer_pkg::CFG3_ALARM_EN];
   assign pin22_alarm = alarm_enable & ~pin_sync_reg[0];
   assign pin14_alarm = alarm_enable & (pin14_mode == alert_timer_pkg::PIN14_ALARM)
                        & ~pin_sync_reg[1];
   assign alarm_asserted = pin22_alarm | pin14_alarm;
   assign vid_changed = vid_prev_reg != pin_sync_reg[6:2];
   assign rd_status1 = reg_req.rd & (reg_req.addr == alert_timer_pkg::ADDR_STATUS1);
   assign rd_status2 = reg_req.rd & (reg_req.addr == alert_timer_pkg::ADDR_STATUS2);
   assign rd_timer = reg_req.rd & (reg_req.addr == alert_timer_pkg::ADDR_TIMER);

   // ****************************************
   // Alarm assertion timer
   // ****************************************
   logic [23:0] presc_reg;
   logic [7:0] ticks_reg;
   logic seen_reg;
   logic [7:0] timer_value;
   logic timer_over;

   function automatic logic exceeds_high(input logic [7:0] value, input logic [7:0] limit);
      exceeds_high = value > limit;
   endfunction

   // Bit0 shows a first assertion before the first full step has elapsed
   assign timer_value = (ticks_reg == 8'h00) ? {7'h00, seen_reg} : ticks_reg;
   assign timer_over = exceeds_high(timer_value, timer_limit_reg);

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         presc_reg <= 24'h000000;
         ticks_reg <= 8'h00;
         seen_reg <= 1'b0;
      end else if (rd_timer) begin
         // Read takes priority over counting so the cleared value is never skipped
         presc_reg <= 24'h000000;
         ticks_reg <= 8'h00;
         seen_reg <= alarm_asserted;
      end else if (alarm_asserted) begin
         seen_reg <= 1'b1;
         if (ticks_reg != alert_timer_pkg::TIMER_FULL) begin
            if (presc_reg == 24'(TICK_CYCLES - 1)) begin
               presc_reg <= 24'h000000;
               ticks_reg <= ticks_reg + 8'h01;
            end else begin
               presc_reg <= presc_reg + 24'h000001;
            end
         end
      end
   end

   // ****************************************
   // Status registers
   // ****************************************
   logic [7:0] status2_reg;
   logic [6:0] status1_reg;
   logic [7:0] status2_cond;
   logic [6:0] status1_cond;
   logic [7:0] status1_view;

   always_comb begin
      status2_cond = {limit_events.diode2_fault, limit_events.diode1_fault,
                      1'b0,
                      limit_events.third_fan_slow, limit_events.second_fan_slow,
                      limit_events.first_fan_slow,
                      limit_events.overtemp,
                      vid_change_sel ? vid_changed : limit_events.supply12};
      case (pin14_mode)
         alert_timer_pkg::PIN14_TACH: status2_cond[5] = limit_events.fourth_fan_slow;
         alert_timer_pkg::PIN14_ALARM: status2_cond[5] = alarm_enable & timer_over;
         alert_timer_pkg::PIN14_GENERAL: status2_cond[5] = pin_sync_reg[1];
         default: status2_cond[5] = 1'b0;
      endcase
      status1_cond = {limit_events.remote_two_temp, limit_events.local_temp,
                      limit_events.remote_one_temp, limit_events.supply5,
                      limit_events.supply_main, limit_events.processor_core_supply,
                      alarm_enable ? (timer_over & pin14_mode != alert_timer_pkg::PIN14_ALARM)
                                   : limit_events.supply25};
   end

   // A condition present in the read cycle wins over the clear
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         status2_reg <= 8'h00;
      end else begin
         status2_reg <= status2_cond | (status2_reg & {8{~rd_status2}});
         status2_reg[alert_timer_pkg::BIT_OVERTEMP] <= limit_events.overtemp;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         status1_reg <= 7'h00;
      end else begin
         status1_reg <= status1_cond | (status1_reg & {7{~rd_status1}});
      end
   end

   assign status1_view = {|status2_reg, status1_reg};

   // ****************************************
   // Alert and pin drive
   // ****************************************
   logic alert_active;
   logic alert_reg;
   logic alert_sel;

   assign alert_active = (|(status1_reg & ~mask1_reg[6:0]))
                         | (~mask1_reg[alert_timer_pkg::BIT_SUMMARY]
                            & |(status2_reg & ~mask2_reg));
   assign alert_sel = config3_reg[alert_timer_pkg::CFG3_ALERT_SEL];

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         alert_reg <= 1'b0;
      end else begin
         alert_reg <= alert_active;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         pin10_out <= 1'b0;
         pin10_oe <= 1'b0;
         pin14_out <= 1'b0;
         pin14_oe <= 1'b0;
         fans_full_speed <= 1'b0;
      end else begin
         pin10_out <= alert_sel ? 1'b0 : second_fan_drive_output;
         pin10_oe <= alert_sel ? alert_active : 1'b1;
         pin14_out <= 1'b0;
         pin14_oe <= (pin14_mode == alert_timer_pkg::PIN14_ALERT) & alert_active;
         fans_full_speed <= config3_reg[alert_timer_pkg::CFG3_BOOST]
                            & alarm_asserted & fans_running;
      end
   end

   // ****************************************
   // Register read data
   // ****************************************
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_req.rd) begin
         case (reg_req.addr)
            alert_timer_pkg::ADDR_STATUS1: reg_rdata <= status1_view;
            alert_timer_pkg::ADDR_STATUS2: reg_rdata <= status2_reg;
            alert_timer_pkg::ADDR_MASK1: reg_rdata <= mask1_reg;
            alert_timer_pkg::ADDR_MASK2: reg_rdata <= mask2_reg;
            alert_timer_pkg::ADDR_CONFIG3: reg_rdata <= config3_reg;
            alert_timer_pkg::ADDR_TIMER: reg_rdata <= timer_value;
            alert_timer_pkg::ADDR_TIMER_LIMIT: reg_rdata <= timer_limit_reg;
            alert_timer_pkg::ADDR_CONFIG4: reg_rdata <= config4_reg;
            default: reg_rdata <= 8'h00;
         endcase
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   // A read with the cause gone must clear the bit that the cause had set
   sequence s_cond_then_read;
      status2_reg[7] & ~limit_events.diode2_fault & rd_status2;
   endsequence

   // Counting is expected only below full scale and outside a timer read
   sequence s_alarm_running;
      alarm_asserted & ~rd_timer & (ticks_reg != alert_timer_pkg::TIMER_FULL);
   endsequence

   sequence s_read_in_alarm;
      rd_timer & alarm_asserted;
   endsequence

   a_sticky_hold: assert property (
      limit_events.diode2_fault & ~rd_status2 ##1 ~rd_status2 |=> status2_reg[7])
      else $error("diode fault bit not held");
   a_read_clear: assert property (
      s_cond_then_read |=> ~status2_reg[7])
      else $error("diode fault bit not cleared by read");
   a_ovt_follow: assert property (
      ##1 status2_reg[1] == $past(limit_events.overtemp))
      else $error("overtemperature bit not tracking");
   a_summary_bit: assert property (
      status1_view[7] == (status2_reg != 8'h00))
      else $error("summary bit wrong");
   a_alert_masked: assert property (
      mask1_reg[alert_timer_pkg::BIT_SUMMARY] && status1_reg == 7'h00 |=> !alert_reg)
      else $error("masked source raised alert");
   a_alert_pin10: assert property (
      alert_sel && alert_active |=> pin10_oe && !pin10_out)
      else $error("pin 10 not pulled low on alert");
   a_timer_pause: assert property (
      !alarm_asserted && !rd_timer |=> $stable(ticks_reg))
      else $error("timer moved while alarm released");
   a_timer_sat: assert property (
      ticks_reg == 8'hff && !rd_timer |=> ticks_reg == 8'hff)
      else $error("timer left full scale");
   a_read_during: assert property (
      s_read_in_alarm |=> timer_value == 8'h01 && presc_reg == 24'h000000)
      else $error("read during assertion wrong");
   a_boost_gate: assert property (
      !fans_running |=> !fans_full_speed)
      else $error("boost with fans stopped");

   // Pins, read data, status setting and timer progress
   a_boost_on: assert property (
      config3_reg[alert_timer_pkg::CFG3_BOOST] && alarm_asserted && fans_running
      |=> fans_full_speed)
      else $error("boost missing while alarm asserted");
   a_status_rdata: assert property (
      rd_status2 |=> reg_rdata == $past(status2_reg))
      else $error("status read data wrong");
   a_rdata_hold: assert property (
      !reg_req.rd |=> $stable(reg_rdata))
      else $error("read data changed without a read");
   a_status2_set: assert property (
      status2_cond != 8'h00
      |=> (status2_reg & $past(status2_cond)) == $past(status2_cond))
      else $error("second status bit not set by its condition");
   a_status1_set: assert property (
      status1_cond != 7'h00
      |=> (status1_reg & $past(status1_cond)) == $past(status1_cond))
      else $error("first status bit not set by its condition");
   a_vid_flag: assert property (
      vid_change_sel && vid_changed |=> status2_reg[0])
      else $error("identity change not flagged");
   a_pin10_drive: assert property (
      !alert_sel
      |=> pin10_oe && pin10_out == $past(second_fan_drive_output))
      else $error("pin 10 not carrying fan drive");
   a_pin14_alert: assert property (
      pin14_mode == alert_timer_pkg::PIN14_ALERT && alert_active |=> pin14_oe && !pin14_out)
      else $error("pin 14 not pulled low on alert");
   a_pin14_quiet: assert property (
      pin14_mode != alert_timer_pkg::PIN14_ALERT |=> !pin14_oe)
      else $error("pin 14 driven outside alert mode");
   a_alarm_gate: assert property (
      !alarm_enable |-> !alarm_asserted)
      else $error("alarm input live while disabled");
   a_first_value: assert property (
      s_alarm_running |=> timer_value != 8'h00)
      else $error("timer shows nothing during an assertion");
   a_timer_runs: assert property (
      s_alarm_running
      |=> {ticks_reg, presc_reg} != $past({ticks_reg, presc_reg}))
      else $error("timer stalled while alarm asserted");
   a_timer_flag: assert property (
      alarm_enable && timer_over && pin14_mode == alert_timer_pkg::PIN14_ALARM
      |=> status2_reg[5])
      else $error("timer over limit not flagged");
   a_limit_zero: assert property (
      s_read_in_alarm ##0 (timer_limit_reg == 8'h00)
      |=> ##1 (pin14_mode == alert_timer_pkg::PIN14_ALARM ? status2_reg[5] : status1_reg[0]))
      else $error("zero limit not flagged after read in assertion");
endmodule
`default_nettype wire

// ==== core/alert_timer_pkg.sv ====
// Purpose: Constants and carriers for the alert status, mask and alarm timer block
// Assumes: 20 MHz system clock, byte-wide register port from the serial interface logic
// Notes: Register offsets are the byte addresses seen by the serial host
package alert_timer_pkg;
   localparam logic [7:0] ADDR_STATUS1 = 8'h41;
   localparam logic [7:0] ADDR_STATUS2 = 8'h42;
   localparam logic [7:0] ADDR_MASK1 = 8'h74;
   localparam logic [7:0] ADDR_MASK2 = 8'h75;
   localparam logic [7:0] ADDR_CONFIG3 = 8'h78;
   localparam logic [7:0] ADDR_TIMER = 8'h79;
   localparam logic [7:0] ADDR_TIMER_LIMIT = 8'h7a;
   localparam logic [7:0] ADDR_CONFIG4 = 8'h7d;

   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic [7:0] CONFIG_RESET = 8'h00;
   localparam logic [7:0] TIMER_LIMIT_RESET = 8'h00;
   localparam logic [7:0] TIMER_FULL = 8'hff;

   localparam int BIT_SUMMARY = 7;
   localparam int BIT_FOURTH_FAN_SLOW = 5;
   localparam int BIT_OVERTEMP = 1;
   localparam int BIT_V25 = 0;
   localparam int CFG3_ALERT_SEL = 0;
   localparam int CFG3_ALARM_EN = 1;
   localparam int CFG3_BOOST = 2;

   localparam int CLK_PERIOD_NS = 50;
   localparam int TIMER_STEP_NS = 22760000;
   localparam int TIMER_STEP_CYCLES = TIMER_STEP_NS / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      PIN14_TACH = 2'b00,
      PIN14_ALARM = 2'b01,
      PIN14_ALERT = 2'b10,
      PIN14_GENERAL = 2'b11
   } pin14_mode_e;

   // Out-of-limit levels from the measurement and tach logic
   typedef struct packed {
      logic diode2_fault;
      logic diode1_fault;
      logic fourth_fan_slow;
      logic third_fan_slow;
      logic second_fan_slow;
      logic first_fan_slow;
      logic overtemp;
      logic supply12;
      logic remote_two_temp;
      logic local_temp;
      logic remote_one_temp;
      logic supply5;
      logic supply_main;
      logic processor_core_supply;
      logic supply25;
   } limit_events_s;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_s;
endpackage

// ==== tb/alert_status_and_alarm_assertion_timer_tb_top.sv ====
// Purpose: Self-checking bench for status, alert masking, pin select and alarm timer
// Assumes: Timer step shortened to TICK cycles
// Notes: Alert on an open-drain pin is active while oe is high and out is low
`timescale 1ns/1ps
`default_nettype none
module alert_status_and_alarm_assertion_timer_tb_top;
   localparam int TICK = 8;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   alert_timer_pkg::reg_req_s reg_req;
   alert_timer_pkg::limit_events_s limit_events = '0;
   logic [7:0] reg_rdata;
   logic vid_change_sel = 1'b0;
   logic [4:0] voltage_id_inputs = 5'h00;
   logic pin22_in_n = 1'b1;
   logic pin14_in = 1'b0;
   logic second_fan_drive_output = 1'b1;
   logic fans_running = 1'b0;
   logic pin10_out, pin10_oe, pin14_out, pin14_oe, fans_full_speed;
   int mismatches = 0;
   int checks_done = 0;

   always #25 mclk = ~mclk;

   alert_status_and_alarm_assertion_timer #(.TICK_CYCLES(TICK)) dut (.mclk(mclk), .sys_rst(sys_rst),
      .reg_req(reg_req), .reg_rdata(reg_rdata), .limit_events(limit_events),
      .vid_change_sel(vid_change_sel), .voltage_id_inputs(voltage_id_inputs),
      .pin22_in_n(pin22_in_n), .pin14_in(pin14_in),
      .second_fan_drive_output(second_fan_drive_output), .fans_running(fans_running),
      .pin10_out(pin10_out), .pin10_oe(pin10_oe), .pin14_out(pin14_out),
      .pin14_oe(pin14_oe), .fans_full_speed(fans_full_speed));
   smb_host_model host (.mclk(mclk), .reg_req(reg_req), .reg_rdata(reg_rdata));

   // ********************************
   // Shared tasks
   // ********************************
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp, input string what);
      logic [7:0] d;
      host.read_reg(addr, d);
      check(what, exp, d);
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge mclk);
      @(negedge mclk);
   endtask

   // Holds the alarm pin low for n cycles and checks boost just before release
   task automatic alarm(input int n, input int gap, input logic boost_exp);
      @(posedge mclk) pin22_in_n <= 1'b0;
      settle(n - 1);
      check("boost", 8'(boost_exp), 8'(fans_full_speed));
      @(posedge mclk) pin22_in_n <= 1'b1;
      settle(gap);
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // ********************************
   // Scenarios
   // ********************************
   task automatic t_regs;
      rd_chk(8'h74, 8'h00, "mask1 reset");
      rd_chk(8'h75, 8'h00, "mask2 reset");
      rd_chk(8'h78, 8'h00, "config3 reset");
      rd_chk(8'h7d, 8'h00, "config4 reset");
      check("pin10 fan drive", 8'h01, 8'({pin10_oe, pin10_out} == 2'b11));
      host.write_reg(8'h10, 8'ha5);
      rd_chk(8'h10, 8'h00, "unmapped");
      host.write_reg(8'h75, 8'h5a);
      rd_chk(8'h75, 8'h5a, "mask2 write");
      $display("test regs done");
   endtask

   task automatic t_sources;
      logic [14:0] v;
      host.write_reg(8'h78, 8'h01);
      for (int m = 0; m < 2; m++) begin
         for (int i = 0; i < 15; i++) begin
            v = 15'(m) << i;
            host.write_reg(8'h74, {1'b0, v[6:0]});
            host.write_reg(8'h75, v[14:7]);
            @(posedge mclk) limit_events <= 15'(1) << i;
            settle(4);
            check("alert live", 8'(m == 0), 8'(pin10_oe & ~pin10_out));
            @(posedge mclk) limit_events <= '0;
            settle(4);
            check("alert held", 8'(m == 0 && i != 8), 8'(pin10_oe));
            if (i > 6) rd_chk(8'h41, (i == 8) ? 8'h00 : 8'h80, "summary");
            rd_chk(i > 6 ? 8'h42 : 8'h41, (i == 8) ? 8'h00 : 8'h01 << (i > 6 ? i - 7 : i),
               "status");
            settle(3);
            check("alert off", 8'h00, 8'(pin10_oe));
            rd_chk(i > 6 ? 8'h42 : 8'h41, 8'h00, "status cleared");
         end
      end
      host.write_reg(8'h74, 8'h80);
      host.write_reg(8'h75, 8'h00);
      @(posedge mclk) limit_events <= 15'h4080;
      settle(4);
      check("summary mask", 8'h00, 8'(pin10_oe));
      rd_chk(8'h42, 8'h81, "held status");
      rd_chk(8'h42, 8'h81, "held status");
      @(posedge mclk) limit_events <= '0;
      settle(3);
      rd_chk(8'h42, 8'h81, "held status");
      rd_chk(8'h42, 8'h00, "held status");
      host.write_reg(8'h74, 8'h00);
      $display("test sources done");
   endtask

   task automatic t_vid_pin14;
      @(posedge mclk) vid_change_sel <= 1'b1;
      settle(4);
      @(posedge mclk) voltage_id_inputs <= 5'h15;
      settle(6);
      rd_chk(8'h42, 8'h01, "id change");
      rd_chk(8'h42, 8'h00, "id change");
      host.write_reg(8'h7d, 8'h02);
      @(posedge mclk) limit_events <= 15'h0001;
      settle(4);
      check("pin14 alert", 8'h01, 8'(pin14_oe & ~pin14_out));
      @(posedge mclk) limit_events <= '0;
      rd_chk(8'h41, 8'h01, "status1");
      settle(3);
      check("pin14 idle", 8'h00, 8'(pin14_oe));
      host.write_reg(8'h7d, 8'h03);
      settle(4);
      rd_chk(8'h42, 8'h00, "gpio low");
      @(posedge mclk) pin14_in <= 1'b1;
      settle(4);
      rd_chk(8'h42, 8'h20, "gpio high");
      @(posedge mclk) pin14_in <= 1'b0;
      settle(4);
      rd_chk(8'h42, 8'h20, "gpio sticky");
      rd_chk(8'h42, 8'h00, "gpio clear");
      host.write_reg(8'h7d, 8'h00);
      $display("test id and pin14 done");
   endtask

   task automatic t_timer;
      logic [7:0] d;
      host.write_reg(8'h78, 8'h04);
      @(posedge mclk) fans_running <= 1'b1;
      alarm(20, 5, 1'b0);
      rd_chk(8'h79, 8'h00, "timer off");
      host.write_reg(8'h78, 8'h06);
      alarm(28, 6, 1'b1);
      rd_chk(8'h79, 8'h03, "timer count");
      rd_chk(8'h79, 8'h00, "timer cleared");
      rd_chk(8'h41, 8'h01, "timer flag");
      rd_chk(8'h41, 8'h00, "flag cleared");
      alarm(14, 30, 1'b1);
      alarm(14, 6, 1'b1);
      rd_chk(8'h79, 8'h03, "timer resumed");
      host.read_reg(8'h41, d);
      @(posedge mclk) fans_running <= 1'b0;
      alarm(6, 6, 1'b0);
      rd_chk(8'h79, 8'h01, "first assertion");
      host.read_reg(8'h41, d);
      @(posedge mclk) pin22_in_n <= 1'b0;
      settle(20);
      rd_chk(8'h79, 8'h02, "read in assertion");
      rd_chk(8'h79, 8'h01, "restart value");
      rd_chk(8'h41, 8'h01, "zero limit flag");
      @(posedge mclk) pin22_in_n <= 1'b1;
      settle(4);
      host.read_reg(8'h79, d);
      host.read_reg(8'h41, d);
      alarm(2100, 6, 1'b0);
      rd_chk(8'h79, 8'hff, "saturated");
      host.read_reg(8'h41, d);
      host.write_reg(8'h7a, 8'h02);
      alarm(20, 6, 1'b0);
      rd_chk(8'h41, 8'h00, "at limit");
      alarm(8, 6, 1'b0);
      rd_chk(8'h41, 8'h01, "over limit");
      host.read_reg(8'h79, d);
      host.read_reg(8'h41, d);
      host.write_reg(8'h7a, 8'h00);
      @(posedge mclk) pin14_in <= 1'b1;
      host.write_reg(8'h7d, 8'h01);
      settle(4);
      @(posedge mclk) pin14_in <= 1'b0;
      settle(12);
      rd_chk(8'h42, 8'h20, "pin14 alarm flag");
      rd_chk(8'h41, 8'h80, "pin14 summary");
      @(posedge mclk) pin14_in <= 1'b1;
      settle(4);
      host.read_reg(8'h79, d);
      rd_chk(8'h42, 8'h20, "pin14 flag held");
      rd_chk(8'h42, 8'h00, "pin14 flag cleared");
      $display("test timer done");
   endtask

   // ********************************
   // Sequence and watchdog
   // ********************************
   initial begin
      repeat (5) @(posedge mclk);
      sys_rst <= 1'b0;
      settle(2);
      t_regs();
      t_sources();
      t_vid_pin14();
      t_timer();
      tally_and_finish();
   end

   // Whole run needs well under 8000 cycles
   initial begin
      repeat (20000) @(posedge mclk);
      mismatches++;
      tally_and_finish();
   end
endmodule
`default_nettype wire

// ==== tb/smb_host_model.sv ====
// Purpose: Host side of the register port, issuing single byte reads and writes
// Assumes: Strobes are one cycle wide and sampled on the rising edge of mclk
// Notes: Released address and data show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module smb_host_model (
   input wire logic mclk,
   output var alert_timer_pkg::reg_req_s reg_req,
   input wire logic [7:0] reg_rdata
);
   // ********************************
   // Register access
   // ********************************
   initial reg_req = '0;

   task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
      @(posedge mclk);
      reg_req <= '{rd: 1'b0, wr: 1'b1, addr: addr, wdata: data};
      @(posedge mclk);
      // A released bus must not look like a held one
      reg_req <= '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~data};
   endtask

   task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
      @(posedge mclk);
      reg_req <= '{rd: 1'b1, wr: 1'b0, addr: addr, wdata: 8'h00};
      @(posedge mclk);
      reg_req <= '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: 8'hff};
      @(negedge mclk);
      data = reg_rdata;
   endtask
endmodule
`default_nettype wire
